// ---- logic/isp_port.sv ----
// Serial audio port: register slave, clock generation, framing and shift engine
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "isp_cfg.svh"
module isp_port
  import isp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  input  wire logic        wsIn,
  output logic             wsOut,
  output logic             wsOe,
  input  wire logic        sdIn,
  output logic             sdOut,
  output logic             sdOe,
  output logic             mckOut,
  output logic             irq,
  output logic             dmaTxReq,
  output logic             dmaRxReq
);
  logic       rstS1;
  logic       rstSync;
  isp_state_t st;
  isp_state_t n;
  isp_fmt_t   fmt;
  logic       active;
  logic       master;
  logic       txm;
  logic       cpol;
  logic       wide;
  logic [5:0] lastPos;
  logic [5:0] slotLen;
  logic [5:0] dlenBits;
  logic [5:0] off;
  logic [5:0] nextPos;
  logic [5:0] np1;
  logic [5:0] evPos;
  logic [5:0] sp;
  logic [5:0] d;
  logic [5:0] start;
  logic [2:0] need;
  logic [15:0] newSh;
  logic       tick;
  logic       bckTgl;
  logic       shiftEv;
  logic       sampleEv;
  logic       valid;
  logic       loadNow;
  logic       pushNow;
  logic       udr;
  logic       ovf;
  logic       rdData;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstS1   <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstS1   <= 1'b1;
      rstSync <= rstS1;
    end
  end

  // Next-state logic for the whole port
  always_comb begin
    n        = st;
    fmt      = isp_fmt_t'(st.ctrl[`ISP_C_FMT]);
    active   = st.ctrl[`ISP_C_EN];
    master   = st.ctrl[`ISP_C_MST];
    txm      = st.ctrl[`ISP_C_TX];
    cpol     = st.ctrl[`ISP_C_CPOL];
    // 24/32-bit samples cannot fit a 16-bit slot, so they force 32
    wide     = st.ctrl[`ISP_C_CH32] || (st.ctrl[`ISP_C_DLEN] != 2'b00);
    slotLen  = wide ? 6'h20 : 6'h10;
    lastPos  = (fmt == FMT_PCM) ? (slotLen - 6'h01) : (wide ? 6'h3F : 6'h1F);
    unique case (st.ctrl[`ISP_C_DLEN])
      2'b00:   dlenBits = 6'h10;
      2'b01:   dlenBits = 6'h18;
      default: dlenBits = 6'h20;
    endcase
    off      = (fmt == FMT_RIGHT) ? (slotLen - dlenBits) : 6'h00;
    rdData   = rd && (addr == `ISP_A_DATA);
    tick     = 1'b0;
    bckTgl   = 1'b0;
    shiftEv  = 1'b0;
    sampleEv = 1'b0;
    loadNow  = 1'b0;
    pushNow  = 1'b0;
    udr      = 1'b0;
    ovf      = 1'b0;
    need     = 3'h0;
    newSh    = 16'h0000;
    start    = 6'h00;
    // Pin synchronisers; a change counts once stages two and three agree
    n.y1     = {sckIn, wsIn, sdIn};
    n.y2     = st.y1;
    n.y3     = st.y2;
    n.fl     = (st.y2 & st.y3) | (st.fl & (st.y2 ^ st.y3));
    n.prevSck = st.fl[2];
    // Prescaler, master clock and bit clock
    tick     = active && master && (st.pcnt == st.div);
    n.pcnt   = (tick || !(active && master)) ? 8'h00 : st.pcnt + 8'h01;
    if (st.ctrl[`ISP_C_MCKOE]) begin
      need = wide ? `ISP_MCK_R32 : `ISP_MCK_R16;
    end
    bckTgl   = tick && (st.rcnt == need);
    if (tick) begin
      n.mck  = ~st.mck;
      n.rcnt = bckTgl ? 3'h0 : st.rcnt + 3'h1;
    end
    // Edges: shift on the falling, sample on the rising of the clock seen through the polarity
    if (master) begin
      if (bckTgl) begin
        n.q      = ~st.q;
        shiftEv  = st.q;
        sampleEv = !st.q;
      end
    end else if (active && (st.fl[2] != st.prevSck)) begin
      shiftEv  = st.prevSck ^ cpol;
      sampleEv = !(st.prevSck ^ cpol);
    end
    nextPos  = (st.pos == lastPos) ? 6'h00 : st.pos + 6'h01;
    np1      = (nextPos == lastPos) ? 6'h00 : nextPos + 6'h01;
    evPos    = shiftEv ? nextPos : st.pos;
    // Slave frame alignment from word select, taken on sample edges
    if (sampleEv && !master) begin
      n.prevWs = st.fl[1];
      if ((fmt == FMT_PCM) ? (st.fl[1] && !st.prevWs) : (st.fl[1] != st.prevWs)) begin
        start = (fmt != FMT_PCM && st.fl[1]) ? slotLen : 6'h00;
        if (fmt == FMT_I2S || (fmt == FMT_PCM && st.ctrl[`ISP_C_PSHORT])) begin
          evPos = (start == 6'h00) ? lastPos : start - 6'h01;
        end else begin
          evPos = start;
        end
        n.pos = evPos;
      end
    end
    sp       = wide ? {1'b0, evPos[4:0]} : {2'b00, evPos[3:0]};
    d        = sp - off;
    valid    = (sp >= off) && (d < dlenBits);
    // Transmit: a fresh half-word at data bits 0 and 16, then shift out MSB first
    if (shiftEv) begin
      n.pos = nextPos;
      if (txm && valid) begin
        if (d == 6'h00 || d == 6'h10) begin
          loadNow = 1'b1;
          if (st.txFull) begin
            n.sdOut  = st.txBuf[15];
            n.sh     = {st.txBuf[14:0], 1'b0};
            n.txFull = 1'b0;
          end else begin
            udr     = 1'b1;
            n.sdOut = 1'b0;
            n.sh    = 16'h0000;
          end
        end else begin
          n.sdOut = st.sh[15];
          n.sh    = {st.sh[14:0], 1'b0};
        end
      end else begin
        n.sdOut = 1'b0;                                              // Padding bits
      end
      if (master) begin
        unique case (fmt)
          FMT_I2S:   n.wsOut = wide ? np1[5] : np1[4];
          FMT_PCM:   n.wsOut = st.ctrl[`ISP_C_PSHORT] ? (nextPos == lastPos) :
                               (nextPos < `ISP_PCM_LONG);
          default:   n.wsOut = wide ? nextPos[5] : nextPos[4];
        endcase
      end
    end
    // Receive: shift in MSB first, hand over each completed half-word
    if (sampleEv && !txm && valid) begin
      newSh = {st.sh[14:0], st.fl[0]};
      n.sh  = newSh;
      if (d == 6'h0F || d == 6'h1F || d == dlenBits - 6'h01) begin
        pushNow = 1'b1;
        if (st.rxFull && !rdData) begin
          ovf = 1'b1;
        end else begin
          n.rxBuf  = (d == 6'h17) ? {newSh[7:0], 8'h00} : newSh;
          n.rxFull = 1'b1;
        end
      end
    end
    // Disabled port parks the clock at its idle level and rewinds the frame
    if (!active) begin
      n.q    = 1'b0;
      n.mck  = 1'b0;
      n.rcnt = 3'h0;
      n.pos  = lastPos;
      n.wsOut = 1'b0;
      n.sdOut = 1'b0;
    end
    // Register writes; a data write after a load this cycle still marks full
    if (wr) begin
      unique case (addr)
        `ISP_A_CTRL:  n.ctrl   = wdata[12:0];
        `ISP_A_PRESC: n.div    = wdata[7:0];
        `ISP_A_DATA: begin
          n.txBuf  = wdata;
          n.txFull = 1'b1;
        end
        `ISP_A_MASK:  n.mask   = wdata[1:0];
        default: ;
      endcase
    end
    // Sticky flags: a new event wins over a write-one clear
    n.status = (st.status & ~((wr && addr == `ISP_A_STAT) ? wdata[1:0] : 2'b00)) |
               {ovf, udr};
    if (rdData && !pushNow) begin
      n.rxFull = 1'b0;
    end
    // Read data stands for the one cycle after the strobe
    n.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        `ISP_A_CTRL:  n.rdata = {3'h0, st.ctrl};
        `ISP_A_PRESC: n.rdata = {8'h00, st.div};
        `ISP_A_DATA:  n.rdata = st.rxBuf;
        `ISP_A_STAT:  n.rdata = {11'h000, st.wsOut | st.fl[1], st.rxFull, st.txFull, st.status};
        `ISP_A_MASK:  n.rdata = {14'h0000, st.mask};
        default:      n.rdata = 16'h0000;
      endcase
    end
    // Registered pins: master drives clock and word select, direction picks data drive
    n.sckOut = (n.q & n.ctrl[`ISP_C_EN] & n.ctrl[`ISP_C_MST]) ^ n.ctrl[`ISP_C_CPOL];
    n.sckOe  = n.ctrl[`ISP_C_EN] && n.ctrl[`ISP_C_MST];
    n.wsOe   = n.sckOe;
    n.sdOe   = n.ctrl[`ISP_C_EN] && n.ctrl[`ISP_C_TX];
    n.mckOut = n.mck && n.ctrl[`ISP_C_MCKOE] && n.sckOe;
    n.irq    = |(n.status & n.mask);
    n.dmaTx  = n.ctrl[`ISP_C_DMATX] && n.sdOe && !n.txFull;
    n.dmaRx  = n.ctrl[`ISP_C_DMARX] && n.rxFull;
  end

  // State register
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      st      <= '0;
      st.ctrl <= `ISP_CTRL_RST;
      st.div  <= `ISP_DIV_RST;
    end else begin
      st <= n;
    end
  end

  assign rdata    = st.rdata;
  assign sckOut   = st.sckOut;
  assign sckOe    = st.sckOe;
  assign wsOut    = st.wsOut;
  assign wsOe     = st.wsOe;
  assign sdOut    = st.sdOut;
  assign sdOe     = st.sdOe;
  assign mckOut   = st.mckOut;
  assign irq      = st.irq;
  assign dmaTxReq = st.dmaTx;
  assign dmaRxReq = st.dmaRx;

  // Checks on the port's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync);

  master_drive_a: assert property (st.sckOe |-> st.ctrl[`ISP_C_MST] && st.ctrl[`ISP_C_EN])
    else $error("clock driven outside master mode");
  half_duplex_a: assert property (st.sdOe |-> st.ctrl[`ISP_C_TX] && st.ctrl[`ISP_C_EN])
    else $error("data driven while receiving");
  rx_no_drive_a: assert property (st.ctrl[`ISP_C_EN] && !st.ctrl[`ISP_C_TX] |=> !st.sdOe)
    else $error("data pin driven in receive mode");
  presc_period_a: assert property (active && master && !tick |=> st.pcnt == $past(st.pcnt) + 8'h01)
    else $error("prescaler period wrong");
  idle_level_a: assert property (!st.ctrl[`ISP_C_EN] && !wr |=> st.sckOut == st.ctrl[`ISP_C_CPOL])
    else $error("clock not at idle level");
  underrun_flag_a: assert property (loadNow && !st.txFull |=> st.status[`ISP_S_UDR])
    else $error("underrun not flagged");
  overrun_flag_a: assert property (pushNow && st.rxFull && !rdData |=> st.status[`ISP_S_OVR])
    else $error("overflow not flagged");
  msb_first_a: assert property (loadNow && st.txFull |=> st.sdOut == $past(st.txBuf[15]))
    else $error("first bit is not the MSB");
  dma_tx_req_a: assert property (wr && addr == `ISP_A_DATA |=> !st.dmaTx)
    else $error("transmit request stays after data write");
  dma_rx_req_a: assert property (pushNow && !st.rxFull && st.ctrl[`ISP_C_DMARX] && !wr |=> st.dmaRx)
    else $error("receive request missing");
  mck_toggle_a: assert property (tick && st.mckOut ##1 st.sckOe && st.ctrl[`ISP_C_MCKOE] |-> !st.mckOut)
    else $error("master clock did not toggle");

  underrun_seen_c: cover property (udr);
  overflow_seen_c: cover property (ovf);
  rx_push_c: cover property (pushNow && st.ctrl[`ISP_C_DLEN] == 2'b01);
  frame_wrap_c: cover property (shiftEv && master && nextPos == 6'h00);
endmodule

// ---- logic/isp_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the serial audio port
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
`define ISP_A_CTRL   8'h00
`define ISP_A_PRESC  8'h04
`define ISP_A_DATA   8'h08
`define ISP_A_STAT   8'h0C
`define ISP_A_MASK   8'h10
`define ISP_C_EN     0
`define ISP_C_MST    1
`define ISP_C_TX     2
`define ISP_C_CPOL   3
`define ISP_C_FMT    5:4
`define ISP_C_DLEN   7:6
`define ISP_C_CH32   8
`define ISP_C_PSHORT 9
`define ISP_C_MCKOE  10
`define ISP_C_DMATX  11
`define ISP_C_DMARX  12
`define ISP_S_UDR    0
`define ISP_S_OVR    1
`define ISP_CTRL_RST 13'h0000
`define ISP_DIV_RST  8'h00
`define ISP_PCM_LONG 6'h0D
`define ISP_MCK_R16  3'h7
`define ISP_MCK_R32  3'h3
`endif

// ---- logic/isp_pkg.sv ----
// Types of the serial audio port
package isp_pkg;
  typedef enum logic [1:0] {
    FMT_I2S   = 2'b00,
    FMT_LEFT  = 2'b01,
    FMT_RIGHT = 2'b10,
    FMT_PCM   = 2'b11
  } isp_fmt_t;

  typedef struct packed {
    logic [12:0] ctrl;
    logic [7:0]  div;
    logic [1:0]  mask;
    logic [1:0]  status;
    logic [15:0] txBuf;
    logic        txFull;
    logic [15:0] rxBuf;
    logic        rxFull;
    logic [15:0] sh;
    logic [5:0]  pos;
    logic [7:0]  pcnt;
    logic [2:0]  rcnt;
    logic        mck;
    logic        q;
    logic        prevWs;
    logic        prevSck;
    logic [2:0]  y1;
    logic [2:0]  y2;
    logic [2:0]  y3;
    logic [2:0]  fl;
    logic        sckOut;
    logic        sckOe;
    logic        wsOut;
    logic        wsOe;
    logic        sdOut;
    logic        sdOe;
    logic        mckOut;
    logic        irq;
    logic        dmaTx;
    logic        dmaRx;
    logic [15:0] rdata;
  } isp_state_t;
endpackage

// ---- verif/isp_codec_model.sv ----
// Behavioural audio codec on the far side of the serial audio port
`timescale 1ns/10ps
module isp_codec_model (
  input  wire logic        sck,
  input  wire logic        ws,
  input  wire logic        sdFromPort,
  input  wire logic        run,
  input  wire logic [15:0] word,
  output logic             sckDrv,
  output logic             wsDrv,
  output logic             sdDrv,
  output logic [15:0]      prevWord,
  output logic [15:0]      lastWord
);
  logic [15:0] sh = 16'h0000;
  logic [4:0]  cnt = 5'h00;
  logic        wsSeen = 1'b0;
  realtime     lastRise = 0.0;
  int          i;

  // Listener: sample on rising bit clock, restart the slot on a word select change
  initial begin
    prevWord = 16'h0000;
    lastWord = 16'h0000;
  end
  always @(posedge sck) begin
    // First rise after a stand-still only opens the frame; no bit stands on it yet
    if ($realtime - lastRise > 1000.0) begin
      cnt = 5'h00;
      sh = 16'h0000;
    end else if (ws !== wsSeen) begin
      sh = {15'h0000, sdFromPort};
      cnt = 5'h01;
    end else begin
      sh = {sh[14:0], sdFromPort}; // MSB arrives first
      cnt = cnt + 5'h01;
    end
    wsSeen = ws;
    lastRise = $realtime;
    if (cnt == 5'h10) begin
      prevWord <= lastWord;
      lastWord <= sh;
    end
  end

  // Talker: clock master for slave tests; once run is low the clock stops at the end of the current 32-bit frame
  initial begin
    sckDrv = 1'b0;
    wsDrv = 1'b0;
    sdDrv = 1'b0;
    forever begin
      // Released data line keeps changing so a stale bit can never look valid
      while (!run) begin
        sdDrv = ~sdDrv;
        #200;
      end
      for (i = 0; i < 32; i++) begin
        wsDrv = i[4];               // Low for left, high for right, changes with MSB
        sdDrv = word[15 - i[3:0]];  // 16-bit slot, MSB first
        #200 sckDrv = 1'b1;
        #200 sckDrv = 1'b0;
      end
    end
  end
endmodule

// ---- verif/i2s_audio_serial_port_tb_top.sv ----
// Self-checking testbench of the serial audio port
`timescale 1ns/10ps
`include "isp_cfg.svh"
module i2s_audio_serial_port_tb_top;
  logic        clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        sckOut, sckOe, wsOut, wsOe, sdOut, sdOe, mckOut, irq, dmaTxReq, dmaRxReq;
  logic        sckM, wsM, sdM, run;
  logic [15:0] prevWord, lastWord, rv;
  int          n_errors = 0;
  int          tests_run = 0;
  wire logic   sck = sckOe ? sckOut : sckM;
  wire logic   ws = wsOe ? wsOut : wsM;

  isp_port dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sckIn(sck), .sckOut(sckOut), .sckOe(sckOe), .wsIn(ws), .wsOut(wsOut), .wsOe(wsOe), .sdIn(sdM),
    .sdOut(sdOut), .sdOe(sdOe), .mckOut(mckOut), .irq(irq), .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq));
  isp_codec_model codec (.sck(sck), .ws(ws), .sdFromPort(sdOut), .run(run), .word(16'h9A6D),
    .sckDrv(sckM), .wsDrv(wsM), .sdDrv(sdM), .prevWord(prevWord), .lastWord(lastWord));

  // 20 MHz bus clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded wait: 0 transmit request, 1 receive request, 2 interrupt
  task automatic wait_hi(input int sel);
    int k;
    for (k = 0; k < 4000; k++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 && dmaTxReq === 1'b1) || (sel == 1 && dmaRxReq === 1'b1) || (sel == 2 && irq === 1'b1)) return;
    end
    n_errors++;
    $display("mismatch at %0t: wait %0d timed out", $time, sel);
    end_of_test;
  endtask

  task automatic test_regs;
    rd_reg(`ISP_A_CTRL, rv);
    chk(rv, 16'h0000);
    rd_reg(`ISP_A_STAT, rv);
    chk(rv, 16'h0000);
    rd_reg(`ISP_A_MASK, rv);
    chk(rv, 16'h0000);
    wr_reg(`ISP_A_PRESC, 16'h005A);
    wr_reg(8'h14, 16'hFFFF);
    rd_reg(`ISP_A_PRESC, rv);
    chk(rv, 16'h005A);
    rd_reg(8'h14, rv);
    chk(rv, 16'h0000);
    $display("test regs done");
  endtask

  // Master transmit, left-justified 16-bit, two half-words then an underrun
  task automatic test_master_tx;
    int k;
    wr_reg(`ISP_A_PRESC, 16'h0003);
    wr_reg(`ISP_A_MASK, 16'h0001);
    wr_reg(`ISP_A_DATA, 16'hA5C3);
    wr_reg(`ISP_A_CTRL, 16'h0817);
    wait_hi(0);
    wr_reg(`ISP_A_DATA, 16'h3C5A);
    chk({14'h0000, sckOe, sdOe}, 16'h0003);
    for (k = 0; k < 4000 && !(prevWord === 16'hA5C3 && lastWord === 16'h3C5A); k++) @(posedge clk);
    chk(prevWord, 16'hA5C3);
    chk(lastWord, 16'h3C5A);
    wait_hi(2);
    rd_reg(`ISP_A_STAT, rv);
    chk(rv & 16'h0003, 16'h0001);
    wr_reg(`ISP_A_MASK, 16'h0000);
    #1 chk({15'h0000, irq}, 16'h0000);
    wr_reg(`ISP_A_CTRL, 16'h0000);
    wr_reg(`ISP_A_STAT, 16'h0003);
    wr_reg(`ISP_A_MASK, 16'h0001);
    rd_reg(`ISP_A_STAT, rv);
    chk(rv & 16'h0003, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    $display("test master tx done");
  endtask

  // Master clock: 256 rising edges in one frame of two 16-bit slots
  task automatic test_mclk;
    int k;
    int n;
    int edges;
    logic pw;
    logic pm;
    n = 0;
    edges = 0;
    pw = 1'b1;
    pm = 1'b1;
    wr_reg(`ISP_A_MASK, 16'h0000);
    wr_reg(`ISP_A_PRESC, 16'h0000);
    wr_reg(`ISP_A_CTRL, 16'h0417);
    for (k = 0; k < 3000 && edges < 2; k++) begin
      @(posedge clk);
      #1;
      if (edges == 1 && mckOut && !pm) n++;
      if (wsOut && !pw) edges++;
      pw = wsOut;
      pm = mckOut;
    end
    chk(n[15:0], 16'h0100);
    chk({15'h0000, wsOe}, 16'h0001);
    wr_reg(`ISP_A_CTRL, 16'h0000);
    wr_reg(`ISP_A_STAT, 16'h0003);
    $display("test mclk done");
  endtask

  // Slave receive from the codec model, then overflow by not reading
  task automatic test_slave_rx;
    wr_reg(`ISP_A_MASK, 16'h0002);
    wr_reg(`ISP_A_CTRL, 16'h1011);
    run <= 1'b1;
    wait_hi(1);
    rd_reg(`ISP_A_DATA, rv);
    repeat (2) @(posedge clk);
    wait_hi(1);
    rd_reg(`ISP_A_DATA, rv);
    chk(rv, 16'h9A6D);
    @(posedge clk);
    #1 chk({13'h0000, sckOe, sdOe, dmaRxReq}, 16'h0000);
    wait_hi(2);
    rd_reg(`ISP_A_STAT, rv);
    chk(rv & 16'h0002, 16'h0002);
    run <= 1'b0;
    wr_reg(`ISP_A_CTRL, 16'h0000);
    wr_reg(`ISP_A_STAT, 16'h0003);
    rd_reg(`ISP_A_STAT, rv);
    chk(rv & 16'h0003, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    $display("test slave rx done");
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    run = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    test_regs;
    test_master_tx;
    test_mclk;
    test_slave_rx;
    end_of_test;
  end
endmodule
